// ### shared/can_pdo_pkg.sv
package can_pdo_pkg;
	// ----------------------------------------
	// Clocking and sizes
	// ----------------------------------------
	localparam int CLK_NS = 20;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int NUM_CH = 2;
	localparam int MAP_MAX = 2;
	localparam int AW = 16;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [13:0] IDX_ERR_COMM = 14'h1029;
	localparam logic [13:0] IDX_ERR_PROF = 14'h102A;
	localparam logic [13:0] IDX_COMM1 = 14'h1800;
	localparam logic [13:0] IDX_COMM2 = 14'h1801;
	localparam logic [13:0] IDX_TYPE1 = 14'h1810;
	localparam logic [13:0] IDX_TYPE2 = 14'h1811;
	localparam logic [13:0] IDX_MCNT1 = 14'h1A00;
	localparam logic [13:0] IDX_MCNT2 = 14'h1A01;
	localparam logic [13:0] IDX_MAPE = 14'h1A10;
	localparam logic [13:0] IDX_FMODE = 14'h1E00;
	localparam logic [13:0] IDX_STAT = 14'h1E01;
	localparam logic [13:0] IDX_START = 14'h1F80;
	// ----------------------------------------
	// Register select codes
	// ----------------------------------------
	localparam logic [3:0] R_NONE = 4'h0;
	localparam logic [3:0] R_ERRC = 4'h1;
	localparam logic [3:0] R_ERRP = 4'h2;
	localparam logic [3:0] R_COMM = 4'h3;
	localparam logic [3:0] R_TYPE = 4'h4;
	localparam logic [3:0] R_MCNT = 4'h5;
	localparam logic [3:0] R_MAPE = 4'h6;
	localparam logic [3:0] R_FMODE = 4'h7;
	localparam logic [3:0] R_STAT = 4'h8;
	localparam logic [3:0] R_START = 4'h9;
	// ----------------------------------------
	// Field values
	// ----------------------------------------
	localparam logic [10:0] SYNC_ID = 11'h080;
	localparam logic [10:0] NMT_ID = 11'h000;
	localparam logic [10:0] TX1_BASE = 11'h180;
	localparam logic [10:0] TX2_BASE = 11'h280;
	localparam logic [31:0] COB_ON = 32'h4000_0000;
	localparam int COB_OFF_BIT = 31;
	localparam logic [7:0] REACT_PREOP = 8'h00;
	localparam logic [7:0] REACT_KEEP = 8'h01;
	localparam logic [7:0] REACT_STOP = 8'h02;
	localparam logic [7:0] TT_SYNC = 8'h01;
	localparam logic [7:0] TT_EVENT = 8'hFF;
	localparam logic [15:0] ETIME1_DEF = 16'h0064;
	localparam logic [31:0] STARTUP_OPER = 32'h0000_0000;
	localparam logic [31:0] STARTUP_PREOP = 32'h0000_0004;
	localparam logic [7:0] HB_BOOT = 8'h00;
	localparam logic [7:0] HB_STOP = 8'h04;
	localparam logic [7:0] HB_OPER = 8'h05;
	localparam logic [7:0] HB_PREOP = 8'h7F;
	localparam logic [7:0] CMD_START = 8'h01;
	localparam logic [7:0] CMD_STOP = 8'h02;
	localparam logic [7:0] CMD_PREOP = 8'h80;
	localparam logic [31:0] MAP_X = 32'h6010_0010;
	localparam logic [31:0] MAP_Y = 32'h6020_0010;
	localparam logic [23:0] SRC_X = 24'h601000;
	localparam logic [23:0] SRC_Y = 24'h602000;
	localparam logic [7:0] FMODE_USER = 8'hFF;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOP} nmt_t;
	typedef struct packed {
		logic [10:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} frame_t;
	typedef struct packed {
		logic bus_off;
		logic guard_timeout;
		logic hb_timeout;
		logic internal;
	} err_t;
	typedef struct packed {
		nmt_t nmt;
		logic [7:0] react_comm;
		logic [7:0] react_prof;
		logic [31:0] startup;
		logic [7:0] fmode;
		logic [NUM_CH-1:0][31:0] cob;
		logic [NUM_CH-1:0][7:0] ttype;
		logic [NUM_CH-1:0][15:0] etime;
		logic [NUM_CH-1:0][15:0] tmr;
		logic [NUM_CH-1:0][7:0] mcount;
		logic [NUM_CH-1:0][MAP_MAX-1:0][31:0] ment;
		logic [NUM_CH-1:0] pend;
		logic [31:0] ms_cnt;
		logic [31:0] prdata;
		logic tx_valid;
		frame_t tx;
		logic hb_send;
		logic [7:0] hb_code;
	} state_t;
endpackage : can_pdo_pkg

// ### verilog/can_pdo_nmt_control.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RQ1] Serious failure moves state per reaction
// [RQ2] Both reaction entries reset to 00h
// [RQ3] Code 00h: operational goes pre-operational only
// [RQ4] 01h keeps state, 02h stops, rest reserved
// [RQ5] Bus-off, guarding, heartbeat, internal failures react
// [RQ6] Exactly two transmit channels
// [RQ7] Default identifiers 180h/280h plus node
// [RQ8] Identifier top bit disables channel
// [RQ9] Type 01h on SYNC, FFh event-driven
// [RQ10] Event-driven sends on internal events
// [RQ11] Millisecond event timer, zero disables
// [RQ12] Mapping entry holds index, subindex, length
// [RQ13] Count selects entries, sent in order
// [RQ14] Second channel mapping count resets zero
// [RQ15] Master disables, remaps, then re-enables
// [RQ16] Remapping accepted pre-operational or operational
// [RQ17] Function mode reloads mapping defaults
// [RQ18] Self-test pass enters operational, heartbeat 05
// [RQ19] Operational output goes through channel one
// [RQ20] Start-up word selects operational or pre-operational
// [RQ21] SYNC recognised on identifier 080h
// [RQ22] Heartbeat codes 7Fh and 04h
// [RQ23] Send only operational, enabled, nonzero count
module can_pdo_nmt_control import can_pdo_pkg::*; #(
	parameter logic [6:0] NODE_ID = 7'h01,
	parameter int AXES = 2,
	parameter int MS_TICK = MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire frame_t rx,
	input wire err_t err,
	input wire logic self_test_pass,
	input wire logic meas_event,
	input wire logic [15:0] tilt_x,
	input wire logic [15:0] tilt_y,
	output logic tx_valid,
	output frame_t tx,
	input wire logic tx_ready,
	output logic hb_send,
	output logic [7:0] hb_code
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [3:0] decode(input logic [AW-1:0] a);
		logic [13:0] i;
		i = a[AW-1:2];
		case (i)
			IDX_ERR_COMM: return R_ERRC;
			IDX_ERR_PROF: return R_ERRP;
			IDX_COMM1, IDX_COMM2: return R_COMM;
			IDX_TYPE1, IDX_TYPE2: return R_TYPE;
			IDX_MCNT1, IDX_MCNT2: return R_MCNT;
			IDX_MAPE, IDX_MAPE + 14'h1, IDX_MAPE + 14'h2, IDX_MAPE + 14'h3: return R_MAPE;
			IDX_FMODE: return R_FMODE;
			IDX_STAT: return R_STAT;
			IDX_START: return R_START;
			default: return R_NONE;
		endcase
	endfunction : decode

	// [RQ3] Reaction by code
	function automatic nmt_t react(input nmt_t cur, input logic [7:0] code);
		case (code)
			REACT_PREOP: return (cur == NMT_OPER) ? NMT_PREOP : cur;
			REACT_STOP: return NMT_STOP;
			default: return cur;
		endcase
	endfunction : react

	// [RQ22] Heartbeat state codes
	function automatic logic [7:0] hb_of(input nmt_t st);
		case (st)
			NMT_OPER: return HB_OPER;
			NMT_PREOP: return HB_PREOP;
			NMT_STOP: return HB_STOP;
			default: return HB_BOOT;
		endcase
	endfunction : hb_of

	function automatic logic [MAP_MAX-1:0][31:0] def_map();
		logic [MAP_MAX-1:0][31:0] m;
		m = '0;
		m[0] = MAP_X;
		if (AXES > 1) begin
			m[1] = MAP_Y;
		end
		return m;
	endfunction : def_map

	function automatic logic [31:0] source(input logic [23:0] obj, input logic [15:0] x,
		input logic [15:0] y);
		if (obj == SRC_X) begin
			return {{16{x[15]}}, x};
		end
		if (obj == SRC_Y) begin
			return {{16{y[15]}}, y};
		end
		return 32'h0000_0000;
	endfunction : source

	// [RQ12] Pack mapped fields in entry order
	function automatic frame_t build(input logic [10:0] id, input logic [7:0] cnt,
		input logic [MAP_MAX-1:0][31:0] ent, input logic [15:0] x, input logic [15:0] y);
		frame_t f;
		int pos;
		int len;
		logic [63:0] v;
		f = '0;
		pos = 0;
		f.id = id;
		for (int i = 0; i < MAP_MAX; i++) begin
			len = int'(ent[i][7:0]);
			if (i < int'(cnt) && len <= 32 && pos + len <= 64) begin
				v = {32'h0000_0000, source(ent[i][31:8], x, y)};
				v = v & ((64'h1 << len) - 64'h1);
				f.data = f.data | (v << pos);
				pos = pos + len;
			end
		end
		f.dlc = 4'((pos + 7) / 8);
		return f;
	endfunction : build

	function automatic state_t rst_state();
		state_t r;
		r = '0;
		r.nmt = NMT_INIT;
		// [RQ2] Both reactions default to pre-operational
		r.react_comm = REACT_PREOP;
		r.react_prof = REACT_PREOP;
		r.startup = STARTUP_OPER;
		// [RQ7] Default identifiers
		r.cob[0] = COB_ON | {21'h0, TX1_BASE + {4'h0, NODE_ID}};
		r.cob[1] = COB_ON | {21'h0, TX2_BASE + {4'h0, NODE_ID}};
		// [RQ9] Event-driven by default
		r.ttype[0] = TT_EVENT;
		r.ttype[1] = TT_EVENT;
		// [RQ11] Channel one timer default
		r.etime[0] = ETIME1_DEF;
		// [RQ13] Default mapping by axis count
		r.mcount[0] = 8'(AXES);
		r.ment[0] = def_map();
		// [RQ14] Channel two mapping off
		r.mcount[1] = 8'h00;
		r.hb_code = HB_BOOT;
		return r;
	endfunction : rst_state

	localparam state_t RST = rst_state();

	// ----------------------------------------
	// State
	// ----------------------------------------
	state_t s;
	state_t next_s;
	logic [3:0] sel;
	logic [13:0] idx;
	logic sync_hit;
	logic cmd_hit;
	logic err_comm;
	logic tick;
	// [RQ6] Two transmit channels
	logic [NUM_CH-1:0] elig;
	logic [NUM_CH-1:0] trig;

	assign idx = paddr[AW-1:2];
	assign sel = decode(paddr);
	// [RQ21] SYNC identifier
	assign sync_hit = rx_valid && rx.id == SYNC_ID;
	assign cmd_hit = rx_valid && rx.id == NMT_ID
		&& (rx.data[15:8] == 8'h00 || rx.data[15:8] == {1'b0, NODE_ID});
	// [RQ5] Communication failure sources
	assign err_comm = err.bus_off | err.guard_timeout | err.hb_timeout;
	assign tick = s.ms_cnt == 32'(MS_TICK - 1);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nmt_t t;
		logic exp;
		logic sent;
		next_s = s;
		t = s.nmt;
		exp = 1'b0;
		sent = 1'b0;
		next_s.hb_send = 1'b0;
		trig = '0;
		elig = '0;
		// Bus read capture in setup phase
		if (psel && !penable) begin
			case (sel)
				R_ERRC: next_s.prdata = {24'h0, s.react_comm};
				R_ERRP: next_s.prdata = {24'h0, s.react_prof};
				R_COMM: next_s.prdata = s.cob[idx[0]];
				R_TYPE: next_s.prdata = {s.etime[idx[0]], 8'h00, s.ttype[idx[0]]};
				R_MCNT: next_s.prdata = {24'h0, s.mcount[idx[0]]};
				R_MAPE: next_s.prdata = s.ment[idx[1]][idx[0]];
				R_FMODE: next_s.prdata = {24'h0, s.fmode};
				R_STAT: next_s.prdata = {22'h0, s.pend, s.hb_code};
				R_START: next_s.prdata = s.startup;
				default: next_s.prdata = 32'h0000_0000;
			endcase
		end
		// [RQ16] Writes accepted in every state
		if (psel && penable && pwrite) begin
			case (sel)
				R_ERRC: begin
					// [RQ4] Reserved codes refused
					if (pwdata[7:0] <= REACT_STOP) begin
						next_s.react_comm = pwdata[7:0];
					end
				end
				R_ERRP: begin
					if (pwdata[7:0] <= REACT_STOP) begin
						next_s.react_prof = pwdata[7:0];
					end
				end
				R_COMM: next_s.cob[idx[0]] = pwdata;
				R_TYPE: begin
					next_s.ttype[idx[0]] = pwdata[7:0];
					next_s.etime[idx[0]] = pwdata[31:16];
				end
				R_MCNT: begin
					if (pwdata[7:0] <= 8'(MAP_MAX)) begin
						next_s.mcount[idx[0]] = pwdata[7:0];
					end
				end
				R_MAPE: next_s.ment[idx[1]][idx[0]] = pwdata;
				R_FMODE: begin
					next_s.fmode = pwdata[7:0];
					// [RQ17] Any mode other than FFh reloads channel one mapping
					if (pwdata[7:0] != FMODE_USER) begin
						next_s.mcount[0] = 8'(AXES);
						next_s.ment[0] = def_map();
					end
				end
				R_START: next_s.startup = pwdata;
				default: next_s.prdata = next_s.prdata;
			endcase
		end
		// Network state machine
		if (s.nmt == NMT_INIT) begin
			// [RQ18] Leave start-up after self-test
			if (self_test_pass) begin
				// [RQ20] Start-up word selects state
				t = (s.startup == STARTUP_OPER) ? NMT_OPER : NMT_PREOP;
			end
		end else begin
			if (cmd_hit) begin
				case (rx.data[7:0])
					CMD_START: t = NMT_OPER;
					CMD_STOP: t = NMT_STOP;
					CMD_PREOP: t = NMT_PREOP;
					default: t = s.nmt;
				endcase
			end
			// [RQ1] Failures override commands
			if (err_comm) begin
				t = react(t, s.react_comm);
			end
			// [RQ5] Internal failure reaction
			if (err.internal) begin
				t = react(t, s.react_prof);
			end
		end
		next_s.nmt = t;
		if (t != s.nmt) begin
			next_s.hb_send = 1'b1;
			next_s.hb_code = hb_of(t);
		end
		// [RQ11] Millisecond tick
		next_s.ms_cnt = tick ? 32'h0000_0000 : s.ms_cnt + 32'h0000_0001;
		for (int c = 0; c < NUM_CH; c++) begin
			exp = 1'b0;
			if (s.etime[c] == 16'h0000) begin
				next_s.tmr[c] = 16'h0000;
			end else if (tick) begin
				if (s.tmr[c] + 16'h0001 >= s.etime[c]) begin
					next_s.tmr[c] = 16'h0000;
					exp = 1'b1;
				end else begin
					next_s.tmr[c] = s.tmr[c] + 16'h0001;
				end
			end
			// [RQ23] Channel may send
			elig[c] = s.nmt == NMT_OPER && !s.cob[c][COB_OFF_BIT] && s.mcount[c] != 8'h00;
			// [RQ9] Synchronous trigger
			trig[c] = s.ttype[c] == TT_SYNC && sync_hit;
			// [RQ10] Event-driven trigger
			if (s.ttype[c] == TT_EVENT && (meas_event || exp)) begin
				trig[c] = 1'b1;
			end
			// [RQ8] Disabled channel drops requests
			if (!elig[c]) begin
				next_s.pend[c] = 1'b0;
			end
		end
		// Transmit handshake
		if (s.tx_valid && tx_ready) begin
			next_s.tx_valid = 1'b0;
		end
		// [RQ19] Channel one first
		if (!s.tx_valid) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (!sent && s.pend[c] && elig[c]) begin
					sent = 1'b1;
					next_s.pend[c] = 1'b0;
					next_s.tx_valid = 1'b1;
					// [RQ13] Frame from active entries
					next_s.tx = build(s.cob[c][10:0], s.mcount[c], s.ment[c], tilt_x, tilt_y);
				end
			end
		end
		// New trigger wins over clear
		for (int c = 0; c < NUM_CH; c++) begin
			if (trig[c] && elig[c]) begin
				next_s.pend[c] = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && sel == R_NONE;
	assign tx_valid = s.tx_valid;
	assign tx = s.tx;
	assign hb_send = s.hb_send;
	assign hb_code = s.hb_code;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_react_stop: assert property ( // [RQ4]
		(s.nmt != NMT_INIT && err.internal && s.react_prof == REACT_STOP)
		|=> s.nmt == NMT_STOP && hb_code == HB_STOP)
		else $error("internal failure did not stop");
	chk_react_preop: assert property ( // [RQ3]
		(s.nmt == NMT_OPER && err_comm && s.react_comm == REACT_PREOP
		&& !err.internal && !cmd_hit)
		|=> s.nmt == NMT_PREOP ##0 hb_send)
		else $error("failure did not give pre-operational");
	chk_react_keep: assert property ( // [RQ3]
		(s.nmt == NMT_PREOP && err_comm && s.react_comm != REACT_STOP
		&& !err.internal && !cmd_hit)
		|=> s.nmt == NMT_PREOP && !hb_send)
		else $error("failure changed pre-operational state");
	chk_startup_oper: assert property ( // [RQ20]
		(s.nmt == NMT_INIT && self_test_pass && s.startup == STARTUP_OPER)
		|=> hb_send && hb_code == HB_OPER)
		else $error("start-up did not reach operational");
	chk_tx_gate: assert property ( // [RQ23]
		$rose(tx_valid) |-> $past(s.nmt) == NMT_OPER)
		else $error("frame sent outside operational");
	chk_disabled_quiet: assert property ( // [RQ8]
		(s.cob[0][COB_OFF_BIT] && s.cob[1][COB_OFF_BIT] && !tx_valid) |=> !tx_valid)
		else $error("disabled channel transmitted");
	chk_sync_pend: assert property ( // [RQ9]
		(sync_hit && s.ttype[0] == TT_SYNC && elig[0]) |=> s.pend[0] || tx_valid)
		else $error("sync did not queue channel one");
	chk_tx_hold: assert property ( // [RQ19]
		(tx_valid && !tx_ready) |=> tx_valid && $stable(tx))
		else $error("frame dropped before acceptance");
	chk_event_send: assert property ( // [RQ10]
		(meas_event && s.ttype[0] == TT_EVENT && elig[0] && !tx_valid && s.pend == '0)
		##1 elig[0] |=> tx_valid && tx.id == s.cob[0][10:0])
		else $error("event did not send channel one");
endmodule : can_pdo_nmt_control
`default_nettype wire

// ### dv/can_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module can_master_model import can_pdo_pkg::*; (
	input wire logic pclk,
	input wire logic slow,
	input wire logic tx_valid,
	input wire frame_t tx,
	output logic tx_ready,
	output logic rx_valid,
	output frame_t rx
);
	int frames;
	frame_t last;
	initial begin
		frames = 0;
		last = '0;
		rx_valid = 1'b0;
		rx = '0;
		tx_ready = 1'b0;
	end
	// ----------------------------------------
	// Frame acceptance, slow takes every other cycle
	// ----------------------------------------
	always @(posedge pclk) begin
		if (tx_valid && tx_ready) begin
			frames <= frames + 1;
			last <= tx;
		end
		tx_ready <= slow ? (tx_valid && !tx_ready) : 1'b1;
	end
	// ----------------------------------------
	// One received frame, bus pattern flips after it
	// ----------------------------------------
	task automatic send(input logic [10:0] id, input logic [63:0] d);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx <= '{id: id, dlc: 4'h8, data: d};
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx <= frame_t'(~rx);
	endtask : send
endmodule : can_master_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import can_pdo_pkg::*;;
	localparam int TICK = 4;
	localparam logic [15:0] A_ERRC = {IDX_ERR_COMM, 2'b00};
	localparam logic [15:0] A_ERRP = {IDX_ERR_PROF, 2'b00};
	localparam logic [15:0] A_COMM1 = {IDX_COMM1, 2'b00};
	localparam logic [15:0] A_COMM2 = {IDX_COMM2, 2'b00};
	localparam logic [15:0] A_TYPE1 = {IDX_TYPE1, 2'b00};
	localparam logic [15:0] A_TYPE2 = {IDX_TYPE2, 2'b00};
	localparam logic [15:0] A_MCNT1 = {IDX_MCNT1, 2'b00};
	localparam logic [15:0] A_MCNT2 = {IDX_MCNT2, 2'b00};
	localparam logic [15:0] A_START = {IDX_START, 2'b00};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic [AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rx_valid, self_test_pass, meas_event, tx_valid, tx_ready, hb_send;
	frame_t rx, tx;
	err_t err;
	logic [15:0] tilt_x, tilt_y;
	logic [7:0] hb_code;
	int mismatches, num_checks, n;
	can_pdo_nmt_control #(.NODE_ID(7'h01), .AXES(2), .MS_TICK(TICK)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx(rx), .err(err), .self_test_pass(self_test_pass),
		.meas_event(meas_event), .tilt_x(tilt_x), .tilt_y(tilt_y), .tx_valid(tx_valid),
		.tx(tx), .tx_ready(tx_ready), .hb_send(hb_send), .hb_code(hb_code));
	can_master_model u_m (.pclk(pclk), .slow(slow), .tx_valid(tx_valid), .tx(tx),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx(rx));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [79:0] got, input logic [79:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		check(pready, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, x);
	endtask : rd
	task automatic wait_hb(input logic s, input logic [7:0] c);
		logic seen;
		seen = 1'b0;
		repeat (6) begin
			#1;
			if (hb_send === 1'b1 && !seen) begin
				seen = 1'b1;
				check(hb_code, c);
			end
			@(posedge pclk);
		end
		check(seen, s);
	endtask : wait_hb
	task automatic wait_frames(input int m);
		int k;
		k = 0;
		while (u_m.frames < m && k < 60) begin
			@(posedge pclk);
			k++;
		end
		repeat (10) @(posedge pclk);
		#1;
		check(u_m.frames, m);
	endtask : wait_frames
	task automatic fail(input logic [15:0] a, input logic [7:0] v, input err_t e,
		input logic s, input logic [7:0] c);
		wr(a, {24'h0, v});
		@(posedge pclk);
		err <= e;
		@(posedge pclk);
		err <= '0;
		wait_hb(s, c);
	endtask : fail
	task automatic nmt(input logic [7:0] cmd, input logic [7:0] c);
		u_m.send(NMT_ID, {48'h0, 8'h01, cmd});
		wait_hb(1'b1, c);
	endtask : nmt
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		rd(A_ERRC, 32'h0);
		rd(A_ERRP, 32'h0);
		rd(A_COMM1, 32'h4000_0181);
		rd(A_COMM2, 32'h4000_0281);
		rd(A_MCNT1, 32'h2);
		rd(A_MCNT2, 32'h0);
		rd(16'h6840, MAP_X);
		rd(16'h6844, MAP_Y);
		rd(16'h7804, 32'h0);
		wr(16'h6840, MAP_Y);
		wr(16'h7800, 32'hFF);
		rd(16'h6840, MAP_Y);
		wr(16'h7800, 32'h0);
		rd(16'h6840, MAP_X);
		rd(A_START, STARTUP_OPER);
		wr(A_START, STARTUP_PREOP);
		rd(A_START, STARTUP_PREOP);
		wr(A_START, STARTUP_OPER);
		wr(A_ERRP, 32'h3);
		rd(A_ERRP, 32'h0);
		apb(1'b0, 16'h0100, 32'h0, r, e);
		check(e, 1'b1);
	endtask : t_regs
	task automatic t_boot();
		@(posedge pclk);
		self_test_pass <= 1'b1;
		wait_hb(1'b1, HB_OPER);
	endtask : t_boot
	task automatic t_sync();
		wr(A_TYPE1, {24'h0, TT_SYNC});
		n = u_m.frames;
		u_m.send(11'h081, 64'h0);
		wait_frames(n);
		u_m.send(SYNC_ID, 64'h0);
		wait_frames(n + 1);
		check(u_m.last, {TX1_BASE + 11'h1, 4'h4, 32'h0, tilt_y, tilt_x});
	endtask : t_sync
	task automatic t_event();
		wr(A_TYPE1, {24'h0, TT_EVENT});
		n = u_m.frames;
		@(posedge pclk);
		meas_event <= 1'b1;
		@(posedge pclk);
		meas_event <= 1'b0;
		wait_frames(n + 1);
		slow <= 1'b1;
		wr(A_TYPE1, {16'h0003, 8'h0, TT_EVENT});
		n = u_m.frames;
		repeat (120) @(posedge pclk);
		check(u_m.frames - n >= 9 && u_m.frames - n <= 11, 1'b1);
		wr(A_TYPE1, {24'h0, TT_SYNC});
		slow <= 1'b0;
	endtask : t_event
	task automatic t_remap();
		wr(A_COMM1, 32'hC000_0181);
		wr(A_COMM2, 32'hC000_0281);
		wr(A_MCNT2, 32'h0);
		wr(16'h6848, MAP_Y);
		wr(A_MCNT2, 32'h1);
		wr(A_COMM2, 32'h4000_0281);
		wr(A_TYPE2, {24'h0, TT_SYNC});
		n = u_m.frames;
		u_m.send(SYNC_ID, 64'h0);
		wait_frames(n + 1);
		check(u_m.last, {TX2_BASE + 11'h1, 4'h2, 48'h0, tilt_y});
		wr(A_COMM1, 32'h4000_0181);
	endtask : t_remap
	task automatic t_errors();
		fail(A_ERRC, REACT_STOP, 4'b1000, 1'b1, HB_STOP);
		n = u_m.frames;
		u_m.send(SYNC_ID, 64'h0);
		wait_frames(n);
		nmt(CMD_START, HB_OPER);
		fail(A_ERRC, REACT_PREOP, 4'b0100, 1'b1, HB_PREOP);
		fail(A_ERRC, REACT_PREOP, 4'b0010, 1'b0, HB_PREOP);
		nmt(CMD_START, HB_OPER);
		fail(A_ERRC, REACT_STOP, 4'b0010, 1'b1, HB_STOP);
		nmt(CMD_START, HB_OPER);
		fail(A_ERRP, REACT_KEEP, 4'b0001, 1'b0, HB_OPER);
		fail(A_ERRP, REACT_STOP, 4'b0001, 1'b1, HB_STOP);
		nmt(CMD_PREOP, HB_PREOP);
		nmt(CMD_STOP, HB_STOP);
	endtask : t_errors
	task automatic t_restart();
		@(posedge pclk);
		self_test_pass <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_MCNT2, 32'h0);
		wr(A_START, STARTUP_PREOP);
		@(posedge pclk);
		self_test_pass <= 1'b1;
		wait_hb(1'b1, HB_PREOP);
	endtask : t_restart
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		mismatches = 0;
		num_checks = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, self_test_pass, meas_event, slow} = '0;
		paddr = '0;
		pwdata = '0;
		err = '0;
		tilt_x = 16'h1234;
		tilt_y = 16'hFEDC;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_boot();
		t_sync();
		t_event();
		t_remap();
		t_errors();
		t_restart();
		give_verdict();
	end
	initial begin
		#400000;
		mismatches++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
